// ==== rtl/adar_pkg.sv ====
// Purpose: constants for the audio dma address register block
// Assumes: ahb-lite word registers, byte address = 4 x printed index
// Notes: printed offsets are half-word spaced, so they are kept as indices
package adar_pkg;

  // ************************************************************
  // register indices (printed offsets) and decode
  // ************************************************************
  localparam logic [31:0] ADAR_IDX_REC_BASE_LOW = 32'h0b000020;
  localparam logic [31:0] ADAR_IDX_REC_BASE_HIGH = 32'h0b000022;
  localparam logic [31:0] ADAR_IDX_REC_NEXT_LOW = 32'h0b000024;
  localparam logic [31:0] ADAR_IDX_REC_NEXT_HIGH = 32'h0b000026;
  localparam logic [31:0] ADAR_IDX_PLAY_BASE_LOW = 32'h0b000028;
  localparam logic [31:0] ADAR_IDX_PLAY_BASE_HIGH = 32'h0b00002a;
  localparam logic [31:0] ADAR_IDX_PLAY_NEXT_LOW = 32'h0b00002c;
  localparam logic [31:0] ADAR_IDX_PLAY_NEXT_HIGH = 32'h0b00002e;
  localparam logic [31:0] ADAR_IDX_CTRL = 32'h0b000038;
  // decoded word offset within the block (index minus first index)
  localparam logic [3:0] ADAR_W_REC_BASE_LOW = 4'h0;
  localparam logic [3:0] ADAR_W_REC_BASE_HIGH = 4'h2;
  localparam logic [3:0] ADAR_W_REC_NEXT_LOW = 4'h4;
  localparam logic [3:0] ADAR_W_REC_NEXT_HIGH = 4'h6;
  localparam logic [3:0] ADAR_W_PLAY_BASE_LOW = 4'h8;
  localparam logic [3:0] ADAR_W_PLAY_BASE_HIGH = 4'ha;
  localparam logic [3:0] ADAR_W_PLAY_NEXT_LOW = 4'hc;
  localparam logic [3:0] ADAR_W_PLAY_NEXT_HIGH = 4'he;

  // ************************************************************
  // field masks and reset values
  // ************************************************************
  localparam logic [15:0] ADAR_BASE_LOW_MASK = 16'hfffe;
  localparam logic [15:0] ADAR_HIGH_MASK = 16'h01ff;
  localparam logic [15:0] ADAR_LOW_RESET = 16'hf800;
  localparam logic [15:0] ADAR_HIGH_RESET = 16'h01ff;
  localparam logic [1:0] ADAR_CTRL_RESET = 2'h0;

  // ************************************************************
  // ring geometry
  // ************************************************************
  localparam int ADAR_PAGE_BIT = 10;
  localparam logic [31:0] ADAR_PAGE_BYTES = 32'h00000400;
  localparam logic [31:0] ADAR_STEP = 32'h00000002;
  localparam logic [31:0] ADAR_OFS_MASK = 32'h000003fe;

  // channel states, gray ordered
  typedef enum logic [1:0] {
    ADAR_IDLE = 2'b00,
    ADAR_RUN = 2'b01
  } adar_state_t;

endpackage

// ==== rtl/adar_chan.sv ====
// Purpose: one dma channel address generator with its ring walk
// Assumes: one half-word transfer per xfer_done pulse
// Notes: next address holds the address the next transfer will use
`timescale 1ns/10ps
module adar_chan (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic [31:0] base_addr,
  input wire logic load_low,
  input wire logic load_high,
  input wire logic [15:0] load_data,
  input wire logic xfer_done,
  output logic [31:0] next_addr,
  output logic running
);

  adar_pkg::adar_state_t state_q;
  logic [31:0] next_q;
  logic [31:0] start_q;
  logic [31:0] inc;
  logic page_end;
  logic second_page_start;

  // address after this transfer and page boundary detect
  assign inc = next_q + adar_pkg::ADAR_STEP;
  assign page_end = (next_q & adar_pkg::ADAR_OFS_MASK) ==
    adar_pkg::ADAR_OFS_MASK;
  assign second_page_start = start_q[adar_pkg::ADAR_PAGE_BIT];
  assign next_addr = next_q;
  assign running = state_q == adar_pkg::ADAR_RUN;

  // run state follows the channel enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= adar_pkg::ADAR_IDLE;
    end else begin
      state_q <= enable ? adar_pkg::ADAR_RUN : adar_pkg::ADAR_IDLE;
    end
  end

  // start address latched from base on start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= {adar_pkg::ADAR_HIGH_RESET, adar_pkg::ADAR_LOW_RESET};
    end else if (enable && state_q == adar_pkg::ADAR_IDLE) begin
      start_q <= base_addr;
    end
  end

  // next address walk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_q <= {adar_pkg::ADAR_HIGH_RESET, adar_pkg::ADAR_LOW_RESET};
    end else if (enable && state_q == adar_pkg::ADAR_IDLE) begin
      next_q <= base_addr;
    end else if (state_q == adar_pkg::ADAR_RUN && xfer_done) begin
      if (!page_end) begin
        next_q <= inc;
      end else if (next_q[adar_pkg::ADAR_PAGE_BIT] == 1'b0) begin
        next_q <= second_page_start ? start_q :
          start_q + adar_pkg::ADAR_PAGE_BYTES;
      end else begin
        next_q <= second_page_start ?
          start_q - adar_pkg::ADAR_PAGE_BYTES : start_q;
      end
    end else if (load_low) begin
      next_q[15:0] <= load_data;
    end else if (load_high) begin
      next_q[31:16] <= load_data & adar_pkg::ADAR_HIGH_MASK;
    end
  end

endmodule // adar_chan

// ==== rtl/adar_top.sv ====
// Purpose: audio record/playback dma address registers on ahb-lite
// Assumes: single word transfers, zero wait states, okay response
// Notes: byte address is four times the printed register index
`timescale 1ns/10ps
module adar_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rec_xfer_done,
  input wire logic play_xfer_done,
  output logic [31:0] rec_dram_addr,
  output logic [31:0] play_dram_addr
);

  // ************************************************************
  // bus address phase capture
  // ************************************************************
  logic [15:0] rec_base_low_q;
  logic [15:0] rec_base_high_q;
  logic [15:0] play_base_low_q;
  logic [15:0] play_base_high_q;
  logic [1:0] ctrl_q;
  logic wr_q;
  logic idx_ctrl_q;
  logic [3:0] widx_q;
  logic hit_q;
  logic [31:0] hrdata_q;
  logic [31:0] idx;
  logic [31:0] rel;
  logic take;
  logic [15:0] wd;
  logic [31:0] rec_next;
  logic [31:0] play_next;
  logic rec_run;
  logic play_run;
  logic [31:0] rec_base;
  logic [31:0] play_base;
  logic [31:0] rd;

  // byte address back to index, relative word
  assign idx = {2'h0, haddr[31:2]};
  assign rel = idx - adar_pkg::ADAR_IDX_REC_BASE_LOW;
  assign take = hsel && hready && htrans[1];
  assign wd = hwdata[15:0];

  // address phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      widx_q <= 4'h0;
      hit_q <= 1'b0;
    end else if (hready) begin
      wr_q <= take && hwrite;
      widx_q <= rel[3:0];
      hit_q <= take && (rel[31:4] == 28'h0000000);
    end
  end

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ************************************************************
  // base registers
  // ************************************************************
  // base low writes, bit 0 held zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_base_low_q <= adar_pkg::ADAR_LOW_RESET;
      play_base_low_q <= adar_pkg::ADAR_LOW_RESET;
    end else if (wr_q && hit_q) begin
      if (widx_q == adar_pkg::ADAR_W_REC_BASE_LOW) begin
        rec_base_low_q <= wd & adar_pkg::ADAR_BASE_LOW_MASK;
      end
      if (widx_q == adar_pkg::ADAR_W_PLAY_BASE_LOW) begin
        play_base_low_q <= wd & adar_pkg::ADAR_BASE_LOW_MASK;
      end
    end
  end

  // base high writes, top bits held zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_base_high_q <= adar_pkg::ADAR_HIGH_RESET;
      play_base_high_q <= adar_pkg::ADAR_HIGH_RESET;
    end else if (wr_q && hit_q) begin
      if (widx_q == adar_pkg::ADAR_W_REC_BASE_HIGH) begin
        rec_base_high_q <= wd & adar_pkg::ADAR_HIGH_MASK;
      end
      if (widx_q == adar_pkg::ADAR_W_PLAY_BASE_HIGH) begin
        play_base_high_q <= wd & adar_pkg::ADAR_HIGH_MASK;
      end
    end
  end

  // channel enables: bit 0 record, bit 1 playback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= adar_pkg::ADAR_CTRL_RESET;
    end else if (wr_q && idx_ctrl_q) begin
      ctrl_q <= hwdata[1:0];
    end
  end

  // control register hit, captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_ctrl_q <= 1'b0;
    end else if (hready) begin
      idx_ctrl_q <= take && idx == adar_pkg::ADAR_IDX_CTRL;
    end
  end

  assign rec_base = {rec_base_high_q, rec_base_low_q};
  assign play_base = {play_base_high_q, play_base_low_q};

  // ************************************************************
  // channels
  // ************************************************************
  // ring walk inside the 2 Kbyte block
  adar_chan u_rec (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(ctrl_q[0]),
    .base_addr(rec_base),
    .load_low(wr_q && hit_q &&
      widx_q == adar_pkg::ADAR_W_REC_NEXT_LOW),
    .load_high(wr_q && hit_q &&
      widx_q == adar_pkg::ADAR_W_REC_NEXT_HIGH),
    .load_data(wd),
    .xfer_done(rec_xfer_done),
    .next_addr(rec_next),
    .running(rec_run)
  );

  adar_chan u_play (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(ctrl_q[1]),
    .base_addr(play_base),
    .load_low(wr_q && hit_q &&
      widx_q == adar_pkg::ADAR_W_PLAY_NEXT_LOW),
    .load_high(wr_q && hit_q &&
      widx_q == adar_pkg::ADAR_W_PLAY_NEXT_HIGH),
    .load_data(wd),
    .xfer_done(play_xfer_done),
    .next_addr(play_next),
    .running(play_run)
  );

  // dram address outputs
  assign rec_dram_addr = rec_next;
  assign play_dram_addr = play_next;

  // ************************************************************
  // read mux
  // ************************************************************
  // control, base and next address readback
  always_comb begin
    rd = 32'h00000000;
    if (idx == adar_pkg::ADAR_IDX_CTRL) begin
      rd = {28'h0000000, play_run, rec_run, ctrl_q};
    end else if (rel[31:4] == 28'h0000000) begin
      unique case (rel[3:0])
        adar_pkg::ADAR_W_REC_BASE_LOW: rd = {16'h0000, rec_base_low_q};
        adar_pkg::ADAR_W_REC_BASE_HIGH: rd = {16'h0000, rec_base_high_q};
        adar_pkg::ADAR_W_REC_NEXT_LOW: rd = {16'h0000, rec_next[15:0]};
        adar_pkg::ADAR_W_REC_NEXT_HIGH: rd = {16'h0000, rec_next[31:16]};
        adar_pkg::ADAR_W_PLAY_BASE_LOW: rd = {16'h0000, play_base_low_q};
        adar_pkg::ADAR_W_PLAY_BASE_HIGH: rd = {16'h0000, play_base_high_q};
        adar_pkg::ADAR_W_PLAY_NEXT_LOW: rd = {16'h0000, play_next[15:0]};
        adar_pkg::ADAR_W_PLAY_NEXT_HIGH: rd = {16'h0000, play_next[31:16]};
        default: rd = 32'h00000000;
      endcase
    end
  end

  // read data registered at end of address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata_q <= rd;
    end
  end
  assign hrdata = hrdata_q;

endmodule // adar_top

// ==== tb/adar_top_sva.sv ====
// Purpose: port checker for the audio dma address register block
// Assumes: zero wait state slave, dma pulses only while a channel runs
// Notes: attached to adar_top by the bind at the foot
`timescale 1ns/10ps
module adar_top_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic rec_xfer_done,
  input wire logic play_xfer_done,
  input wire logic [31:0] rec_dram_addr,
  input wire logic [31:0] play_dram_addr
);
  // ************************************************************
  // data phase markers and properties
  // ************************************************************
  logic wr_q;
  logic wr2_q;
  logic rd_q;

  // marks data phases, and the cycle after a write for enable copies
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wr2_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      wr2_q <= wr_q;
      rd_q <= hsel && hready && htrans[1] && !hwrite;
    end
  end

  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);

  rec_step_a: assert property (
    rec_xfer_done && rec_dram_addr[9:0] != 10'h3fe
    |=> rec_dram_addr == $past(rec_dram_addr) + 32'h2)
    else $error("record step not two bytes");
  play_step_a: assert property (
    play_xfer_done && play_dram_addr[9:0] != 10'h3fe
    |=> play_dram_addr == $past(play_dram_addr) + 32'h2)
    else $error("playback step not two bytes");
  rec_wrap_a: assert property (
    rec_xfer_done && rec_dram_addr[9:0] == 10'h3fe
    |=> rec_dram_addr[10] != $past(rec_dram_addr[10])
    && rec_dram_addr[31:11] == $past(rec_dram_addr[31:11]))
    else $error("record page switch wrong");
  play_wrap_a: assert property (
    play_xfer_done && play_dram_addr[9:0] == 10'h3fe
    |=> play_dram_addr[10] != $past(play_dram_addr[10])
    && play_dram_addr[31:11] == $past(play_dram_addr[31:11]))
    else $error("playback page switch wrong");
  rec_hold_a: assert property (
    !rec_xfer_done && !wr_q && !wr2_q |=> $stable(rec_dram_addr))
    else $error("record address moved without cause");
  play_hold_a: assert property (
    !play_xfer_done && !wr_q && !wr2_q |=> $stable(play_dram_addr))
    else $error("playback address moved without cause");
  rec_top_zero_a: assert property (
    rec_dram_addr[31:25] == 7'h0)
    else $error("record address top bits set");
  read_upper_a: assert property (
    rd_q |-> hrdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
endmodule // adar_top_chk

bind adar_top adar_top_chk u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hrdata(hrdata),
  .rec_xfer_done(rec_xfer_done),
  .play_xfer_done(play_xfer_done),
  .rec_dram_addr(rec_dram_addr),
  .play_dram_addr(play_dram_addr)
);

// ==== tb/adar_dma_req.sv ====
// Purpose: audio unit dma requester, one half-word per request
// Assumes: a request is only made while the channel runs
// Notes: gap sets how many idle cycles pass before the pulse
`timescale 1ns/10ps
module adar_dma_req (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic sel,
  input wire logic [3:0] gap,
  output logic busy,
  output logic rec_done,
  output logic play_done
);
  logic busy_q;
  logic sel_q;
  logic [3:0] cnt_q;

  // counts down the gap after a request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      sel_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (go) begin
      busy_q <= 1'b1;
      sel_q <= sel;
      cnt_q <= gap;
    end else if (busy_q) begin
      busy_q <= cnt_q != 4'h0;
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign rec_done = busy_q && cnt_q == 4'h0 && !sel_q;
  assign play_done = busy_q && cnt_q == 4'h0 && sel_q;
  assign busy = busy_q;
endmodule // adar_dma_req

// ==== tb/adar_top_tb.sv ====
// Purpose: register and ring walk tests for the dma address block
// Assumes: byte address is four times the register index
// Notes: hready is looped back from hreadyout
`timescale 1ns/10ps
module adar_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic sel = 1'b0;
  logic [3:0] gap = 4'h0;
  logic hreadyout, hresp, busy, rec_done, play_done;
  logic [31:0] hrdata, rec_addr, play_addr, rd;
  int n_fail = 0;
  int tests_run = 0;

  // free running clock
  always #5 hclk = ~hclk;

  adar_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rec_xfer_done(rec_done),
    .play_xfer_done(play_done), .rec_dram_addr(rec_addr),
    .play_dram_addr(play_addr));
  adar_dma_req u_req (.hclk(hclk), .hresetn(hresetn), .go(go), .sel(sel),
    .gap(gap), .busy(busy), .rec_done(rec_done), .play_done(play_done));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic edge_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      report_and_stop;
    end
  endtask

  // one single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] idx,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {idx[29:0], 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_rdy;
    r = hrdata;
  endtask

  task automatic wr_rd(input logic [31:0] idx, input logic [31:0] wd,
                       input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b1, idx, wd, r);
    bus(1'b0, idx, 32'h0, r);
    chk(r, exp);
  endtask

  // one dma pulse on a channel, then check its next address
  task automatic step(input logic s, input logic [3:0] g,
                      input logic [31:0] exp);
    int k;
    k = 0;
    go <= 1'b1;
    sel <= s;
    gap <= g;
    @(posedge hclk);
    go <= 1'b0;
    do begin
      @(negedge hclk);
      k++;
    end while (busy !== 1'b0 && k < 40);
    if (busy !== 1'b0) begin
      n_fail++;
      report_and_stop;
    end
    chk(s ? play_addr : rec_addr, exp);
    @(posedge hclk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, adar_pkg::ADAR_IDX_REC_BASE_LOW + 32'(2 * i), 32'h0, rd);
      chk(rd, i[0] ? 32'h000001ff : 32'h0000f800);
    end
    chk({31'h0, hresp}, 32'h0);
    wr_rd(adar_pkg::ADAR_IDX_REC_BASE_LOW, 32'hfffffffe, 32'hfffe);
    wr_rd(adar_pkg::ADAR_IDX_REC_BASE_HIGH, 32'hffff01ff, 32'h1ff);
    wr_rd(adar_pkg::ADAR_IDX_PLAY_BASE_LOW, 32'hfffe, 32'hfffe);
    wr_rd(32'h0b000030, 32'h1234, 32'h0);
    wr_rd(adar_pkg::ADAR_IDX_REC_BASE_LOW, 32'h03fc, 32'h03fc);
    wr_rd(adar_pkg::ADAR_IDX_REC_BASE_HIGH, 32'h0012, 32'h0012);
    wr_rd(adar_pkg::ADAR_IDX_PLAY_BASE_LOW, 32'h07fc, 32'h07fc);
    wr_rd(adar_pkg::ADAR_IDX_PLAY_BASE_HIGH, 32'h0003, 32'h0003);
    bus(1'b1, adar_pkg::ADAR_IDX_CTRL, 32'h1, rd);
    // enable copies base to next one edge after the write lands
    @(posedge hclk);
    bus(1'b0, adar_pkg::ADAR_IDX_REC_NEXT_LOW, 32'h0, rd);
    chk(rd, 32'h03fc);
    bus(1'b0, adar_pkg::ADAR_IDX_REC_NEXT_HIGH, 32'h0, rd);
    chk(rd, 32'h0012);
    step(1'b0, 4'h0, 32'h001203fe);
    step(1'b0, 4'h3, 32'h001207fc);
    step(1'b0, 4'h0, 32'h001207fe);
    step(1'b0, 4'h0, 32'h001203fc);
    bus(1'b1, adar_pkg::ADAR_IDX_CTRL, 32'h3, rd);
    @(posedge hclk);
    bus(1'b0, adar_pkg::ADAR_IDX_PLAY_NEXT_LOW, 32'h0, rd);
    chk(rd, 32'h07fc);
    step(1'b1, 4'h0, 32'h000307fe);
    step(1'b1, 4'h5, 32'h000303fc);
    step(1'b1, 4'h0, 32'h000303fe);
    step(1'b1, 4'h0, 32'h000307fc);
    chk(rec_addr, 32'h001203fc);
    wr_rd(adar_pkg::ADAR_IDX_REC_NEXT_LOW, 32'hffff, 32'hffff);
    chk(rec_addr, 32'h0012ffff);
    report_and_stop;
  end
endmodule // adar_top_tb
